// file: oag_ea_decode.sv
// Combinational decode of the operand field into mode and effective address
module oag_ea_decode (
  input  wire logic [8:0]        operandField,
  input  wire logic [15:0]       indirectPtr,
  input  wire logic [15:0]       dataPtr,
  input  wire logic [15:0]       stackPtr,
  output oag_pkg::oag_mode_e     mode,
  output logic      [11:0]       effAddr
);

  logic        isZero;
  logic [11:0] basePtr;
  logic [11:0] offsetSum;

  // All-zero field is checked first so it never decodes as special register
  assign isZero    = (operandField == 9'h000);                          // RULE19
  // Only twelve pointer bits matter; high nibble of each high byte is dropped
  assign basePtr   = operandField[7] ? stackPtr[11:0] : dataPtr[11:0];  // RULE6 RULE7
  // Sum kept at twelve bits so an overflowing offset wraps
  assign offsetSum = basePtr + {5'h00, operandField[6:0]};              // RULE5 RULE18

  // Mode select
  always_comb begin
    if (isZero) begin
      mode    = oag_pkg::MODE_INDIRECT;                                 // RULE2
      effAddr = indirectPtr[11:0];                                      // RULE7
    end else if (operandField[8]) begin
      mode    = operandField[7] ? oag_pkg::MODE_SP_OFFSET : oag_pkg::MODE_DP_OFFSET; // RULE6
      effAddr = offsetSum;                                              // RULE5
    end else if (operandField[7]) begin
      mode    = oag_pkg::MODE_GLOBAL;                                   // RULE4
      effAddr = oag_pkg::GLOBAL_BASE + {5'h00, operandField[6:0]};      // RULE4
    end else begin
      mode    = oag_pkg::MODE_SPECIAL;                                  // RULE3
      effAddr = {5'h00, operandField[6:0]};                             // RULE3
    end
  end

endmodule

// file: oag_mem_model.sv
// Core-side data memory model recording operand and stack accesses
module oag_mem_model (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [11:0] operandAddr,
  input wire logic [2:0]  operandMode,
  input wire logic        operandStrobe,
  input wire logic [11:0] stackAddr,
  input wire logic        stackStrobe,
  input wire logic        stackPush
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] lastOpAddr;
  logic [2:0]  lastMode;
  logic [11:0] lastStackAddr;
  logic        lastPush;
  int          opCount;
  int          misuse;

  // Sample on strobes only; a pointer hitting the low page or a direct hit above 0x0FF is misuse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opCount <= 0;
      misuse <= 0;
      lastPush <= 1'b0;
    end else begin
      if (operandStrobe) begin
        lastOpAddr <= operandAddr;
        lastMode <= operandMode;
        opCount <= opCount + 1;
        if ((operandMode inside {3'h0, 3'h3, 3'h4}) ? operandAddr < 12'h020 : operandAddr > 12'h0FF) begin
          misuse <= misuse + 1;
        end
      end
      if (stackStrobe) begin
        lastStackAddr <= stackAddr;
        lastPush <= stackPush;
      end
    end
  end
endmodule

// file: oag_pkg.sv
// Constants, modes and register map for the operand address generator
// Behaviour
// RULE1: Nine-bit operand field picks addressing mode and direct address or offset.
// RULE2: All-zero field means indirect; address is the twelve-bit indirect pointer.
// RULE3: Bits 8 and 7 zero, field nonzero: special register at low seven bits.
// RULE4: Bit 8 zero, bit 7 one: global register at 0x080 plus low bits.
// RULE5: Bit 8 set: address is seven-bit unsigned offset plus twelve-bit pointer.
// RULE6: Offset mode uses data pointer when bit 7 clear, stack pointer when set.
// RULE7: Upper four bits of each pointer high byte never reach the address.
// RULE8: Software reaches 0x000-0x01F only directly; pointer addresses stay 0x020-0xFFF. The decoder does not enforce this; oag_mem_model counts it as misuse.
// RULE9: Software reaches 0x100-0xFFF only through indirect or offset modes.
// RULE10: Carry out of a pointer low byte add increments its high byte.
// RULE11: Borrow out of a pointer low byte subtract decrements its high byte.
// RULE12: Two commands load data pointer high and low bytes from an immediate.
// RULE13: Push and pop move stack pointer automatically; stack grows downward.
// RULE14: Pop offset operand uses stack pointer before increment; element uses after.
// RULE15: Data stack pointer is wholly separate from any return-address stack.
// RULE16: Signed and unsigned eight by eight multiply gives sixteen-bit product.
// RULE17: Product high byte goes to multiply-high register, low byte to working register.
// RULE18: Pointer plus offset is cut to twelve bits, wrapping in data space.
// RULE19: All-zero field is indirect although it lies in the special range.
package oag_pkg;

  typedef enum logic [2:0] {
    MODE_INDIRECT,
    MODE_SPECIAL,
    MODE_GLOBAL,
    MODE_DP_OFFSET,
    MODE_SP_OFFSET
  } oag_mode_e;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IPTR   = 8'h08;
  localparam logic [7:0] OFS_DPTR   = 8'h0C;
  localparam logic [7:0] OFS_SPTR   = 8'h10;
  localparam logic [7:0] OFS_MUL    = 8'h14;
  localparam logic [7:0] OFS_WORK   = 8'h18;

  // Command word fields
  localparam int CMD_FIELD_LSB = 0;
  localparam int CMD_OP_LSB    = 9;
  localparam int CMD_IMM_LSB   = 16;
  localparam int CMD_SEL_LSB   = 24;

  // Command opcodes
  localparam logic [3:0] OP_ADDR  = 4'h0;
  localparam logic [3:0] OP_ADD   = 4'h1;
  localparam logic [3:0] OP_SUB   = 4'h2;
  localparam logic [3:0] OP_LOADH = 4'h3;
  localparam logic [3:0] OP_LOADL = 4'h4;
  localparam logic [3:0] OP_PUSH  = 4'h5;
  localparam logic [3:0] OP_POP   = 4'h6;
  localparam logic [3:0] OP_MULU  = 4'h7;
  localparam logic [3:0] OP_MULS  = 4'h8;

  // Pointer select codes for add and subtract
  localparam logic [1:0] SEL_IPTR = 2'h0;
  localparam logic [1:0] SEL_DPTR = 2'h1;
  localparam logic [1:0] SEL_SPTR = 2'h2;

  // Status word fields
  localparam int STAT_MODE_LSB  = 12;
  localparam int STAT_STACK_LSB = 16;

  // Address space constants
  localparam logic [11:0] GLOBAL_BASE = 12'h080;

  // Reset values
  localparam logic [15:0] PTR_RESET  = 16'h0000;
  localparam logic [7:0]  BYTE_RESET = 8'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: oag_props.sv
// Concurrent checks on the operand address generator top ports
module oag_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [11:0] operandAddr,
  input wire logic [2:0]  operandMode,
  input wire logic        operandStrobe,
  input wire logic        stackStrobe,
  input wire logic        stackPush
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Direct modes must stay inside their own page; zero never counts as special
  special_page_a: assert property (operandMode == 3'h1 |-> operandAddr < 12'h080 && operandAddr != 12'h000)
    else $error("special mode address outside its page");
  global_page_a: assert property (operandMode == 3'h2 |-> operandAddr[11:7] == 5'h01)
    else $error("global mode address outside its page");
  mode_code_a: assert property (operandMode <= 3'h4)
    else $error("operand mode code out of range");
  // Operand outputs move only with a command response
  strobe_resp_a: assert property (operandStrobe |-> $rose(s_axi_bvalid))
    else $error("operand strobe without a fresh write response");
  addr_hold_a: assert property (!$rose(s_axi_bvalid) |-> $stable(operandAddr))
    else $error("operand address moved without a command");
  strobe_pulse_a: assert property (operandStrobe |=> !operandStrobe)
    else $error("operand strobe longer than one cycle");
  // Stack traffic always carries an operand transfer too
  stack_pair_a: assert property (stackStrobe |-> operandStrobe)
    else $error("stack strobe without operand strobe");
  push_hold_a: assert property (!stackStrobe |-> $stable(stackPush))
    else $error("push flag moved without stack strobe");
  // Bus handshake sanity
  awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held too long");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before handshake");
endmodule

bind oag_top oag_props u_oag_props (.clk(clk), .rst(rst), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .operandAddr(operandAddr), .operandMode(operandMode),
  .operandStrobe(operandStrobe), .stackStrobe(stackStrobe), .stackPush(stackPush));

// file: oag_ptr_adder.sv
// Pointer byte add or subtract with carry and borrow into the high byte
module oag_ptr_adder (
  input  wire logic [15:0] ptrIn,
  input  wire logic [7:0]  amount,
  input  wire logic        subtract,
  output logic      [15:0] ptrOut
);

  logic [8:0] lowSum;
  logic [7:0] highOut;

  // Ninth bit is carry on add and borrow on subtract
  assign lowSum  = subtract ? ({1'b0, ptrIn[7:0]} - {1'b0, amount})
                            : ({1'b0, ptrIn[7:0]} + {1'b0, amount});
  // High byte moves by one only on a carry or borrow out of the low byte
  assign highOut = !lowSum[8] ? ptrIn[15:8]
                 : subtract   ? ptrIn[15:8] - 8'h01                     // RULE11
                              : ptrIn[15:8] + 8'h01;                    // RULE10
  assign ptrOut  = {highOut, lowSum[7:0]};

endmodule

// file: oag_top.sv
// Operand address generator with pointer, stack and multiply logic behind AXI4-Lite
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
module oag_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [11:0]            operandAddr,
  output logic [2:0]             operandMode,
  output logic                   operandStrobe,
  output logic [11:0]            stackAddr,
  output logic                   stackStrobe,
  output logic                   stackPush
);

  // Architectural registers
  logic [15:0] indirectPtr;
  logic [15:0] dataPtr;
  logic [15:0] stackPtr;
  logic [7:0]  multiply_high_reg;
  logic [7:0]  workReg;

  // Bus holding state
  logic              awHeld;
  logic              wHeld;
  logic [ADDR_W-1:0] awAddrHeld;
  logic [31:0]       wDataHeld;
  logic [3:0]        wStrbHeld;

  // Merge a write with an old value under byte strobes
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Write decode: both channels held and no response outstanding
  logic        doWrite;
  logic        wrCmd;
  logic        wrIptr;
  logic        wrDptr;
  logic        wrSptr;
  logic        wrMul;
  logic        wrWork;
  logic        wrStatus;
  logic        wrHit;
  logic [7:0]  wOfs;
  assign doWrite  = awHeld && wHeld && !s_axi_bvalid;
  assign wOfs     = 8'(awAddrHeld);
  assign wrCmd    = doWrite && (wOfs == oag_pkg::OFS_CMD);
  assign wrIptr   = doWrite && (wOfs == oag_pkg::OFS_IPTR);
  assign wrDptr   = doWrite && (wOfs == oag_pkg::OFS_DPTR);
  assign wrSptr   = doWrite && (wOfs == oag_pkg::OFS_SPTR);
  assign wrMul    = doWrite && (wOfs == oag_pkg::OFS_MUL);
  assign wrWork   = doWrite && (wOfs == oag_pkg::OFS_WORK);
  assign wrStatus = doWrite && (wOfs == oag_pkg::OFS_STATUS);
  assign wrHit    = wrCmd || wrIptr || wrDptr || wrSptr || wrMul || wrWork || wrStatus;

  // Command fields; command bytes not strobed read as zero
  logic [31:0] cmdWord;
  logic [8:0]  operand_field;
  logic [3:0]  cmdOp;
  logic [7:0]  cmdImm;
  logic [1:0]  cmdSel;
  assign cmdWord       = mergeBytes(32'h0000_0000, wDataHeld, wStrbHeld);
  assign operand_field = cmdWord[oag_pkg::CMD_FIELD_LSB +: 9];          // RULE1
  assign cmdOp         = cmdWord[oag_pkg::CMD_OP_LSB +: 4];
  assign cmdImm        = cmdWord[oag_pkg::CMD_IMM_LSB +: 8];
  assign cmdSel        = cmdWord[oag_pkg::CMD_SEL_LSB +: 2];

  // Effective address of the commanded operand from current pointers
  oag_pkg::oag_mode_e decMode;
  logic [11:0]        decAddr;
  oag_ea_decode u_decode (
    .operandField (operand_field),
    .indirectPtr  (indirectPtr),
    .dataPtr      (dataPtr),
    .stackPtr     (stackPtr),
    .mode         (decMode),
    .effAddr      (decAddr)
  );

  // Generic pointer arithmetic on the selected pointer
  logic        opAdd;
  logic        opSub;
  logic [15:0] selPtr;
  logic [15:0] arithPtr;
  assign opAdd  = wrCmd && (cmdOp == oag_pkg::OP_ADD);
  assign opSub  = wrCmd && (cmdOp == oag_pkg::OP_SUB);
  assign selPtr = (cmdSel == oag_pkg::SEL_IPTR) ? indirectPtr
                : (cmdSel == oag_pkg::SEL_DPTR) ? dataPtr : stackPtr;
  oag_ptr_adder u_arith (
    .ptrIn    (selPtr),
    .amount   (cmdImm),
    .subtract (opSub),
    .ptrOut   (arithPtr)
  );

  // Stack pointer step for push and pop; pushing moves toward lower addresses
  logic        opPush;
  logic        opPop;
  logic [15:0] stepPtr;
  assign opPush = wrCmd && (cmdOp == oag_pkg::OP_PUSH);
  assign opPop  = wrCmd && (cmdOp == oag_pkg::OP_POP);
  oag_ptr_adder u_stack (
    .ptrIn    (stackPtr),
    .amount   (8'h01),
    .subtract (opPush),                                                 // RULE13
    .ptrOut   (stepPtr)
  );

  // Multiply of working register by immediate, signed or unsigned
  logic        opMulU;
  logic        opMulS;
  logic [15:0] productU;
  logic [15:0] productS;
  logic [15:0] product;
  assign opMulU   = wrCmd && (cmdOp == oag_pkg::OP_MULU);
  assign opMulS   = wrCmd && (cmdOp == oag_pkg::OP_MULS);
  assign productU = workReg * cmdImm;                                   // RULE16
  assign productS = $signed(workReg) * $signed(cmdImm);                 // RULE16
  assign product  = opMulS ? productS : productU;

  // Next values of pointer registers; bus write and command never coincide
  logic [15:0] next_indirectPtr;
  logic [15:0] next_dataPtr;
  logic [15:0] next_stackPtr;
  logic        arithIp;
  logic        arithDp;
  logic        arithSp;
  assign arithIp = (opAdd || opSub) && (cmdSel == oag_pkg::SEL_IPTR);
  assign arithDp = (opAdd || opSub) && (cmdSel == oag_pkg::SEL_DPTR);
  assign arithSp = (opAdd || opSub) && (cmdSel == oag_pkg::SEL_SPTR);
  assign next_indirectPtr = wrIptr ? 16'(mergeBytes({16'h0000, indirectPtr}, wDataHeld, wStrbHeld))
                          : arithIp ? arithPtr : indirectPtr;           // RULE10 RULE11
  assign next_dataPtr = wrDptr ? 16'(mergeBytes({16'h0000, dataPtr}, wDataHeld, wStrbHeld))
                      : arithDp ? arithPtr                              // RULE10 RULE11
                      : (wrCmd && cmdOp == oag_pkg::OP_LOADH) ? {cmdImm, dataPtr[7:0]}  // RULE12
                      : (wrCmd && cmdOp == oag_pkg::OP_LOADL) ? {dataPtr[15:8], cmdImm} // RULE12
                      : dataPtr;
  // Only push, pop, pointer arithmetic or a bus write touch the data stack;
  // no call or return path exists here, so it cannot mix with return addresses
  assign next_stackPtr = wrSptr ? 16'(mergeBytes({16'h0000, stackPtr}, wDataHeld, wStrbHeld))
                       : arithSp ? arithPtr
                       : (opPush || opPop) ? stepPtr                    // RULE13 RULE15
                       : stackPtr;

  // Pointer and result registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      indirectPtr       <= oag_pkg::PTR_RESET;
      dataPtr           <= oag_pkg::PTR_RESET;
      stackPtr          <= oag_pkg::PTR_RESET;
      multiply_high_reg <= oag_pkg::BYTE_RESET;
      workReg           <= oag_pkg::BYTE_RESET;
    end else begin
      indirectPtr <= next_indirectPtr;
      dataPtr     <= next_dataPtr;
      stackPtr    <= next_stackPtr;
      if (opMulU || opMulS) begin
        multiply_high_reg <= product[15:8];                             // RULE17
        workReg           <= product[7:0];                              // RULE17
      end else begin
        if (wrMul) begin
          multiply_high_reg <= 8'(mergeBytes({16'h0000, multiply_high_reg, workReg}, wDataHeld, wStrbHeld) >> 8);
        end
        if (wrWork) begin
          workReg <= 8'(mergeBytes({24'h000000, workReg}, wDataHeld, wStrbHeld));
        end
      end
    end
  end

  // Operand and stack element addresses; pop operand uses the old stack pointer
  // through the decoder while the element uses the stepped value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      operandAddr   <= 12'h000;
      operandMode   <= 3'h0;
      operandStrobe <= 1'b0;
      stackAddr     <= 12'h000;
      stackStrobe   <= 1'b0;
      stackPush     <= 1'b0;
    end else begin
      operandStrobe <= wrCmd && (cmdOp == oag_pkg::OP_ADDR || opPush || opPop);
      stackStrobe   <= opPush || opPop;
      if (wrCmd) begin
        operandAddr <= decAddr;                                         // RULE1 RULE14
        operandMode <= decMode;
      end
      if (opPush || opPop) begin
        stackAddr <= opPop ? stepPtr[11:0] : stackPtr[11:0];            // RULE13 RULE14 RULE7
        stackPush <= opPush;
      end
    end
  end

  // Write channels: each taken on its own, either order, one write at a time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddrHeld    <= '0;
      wDataHeld     <= 32'h0000_0000;
      wStrbHeld     <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= oag_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !awHeld;
      s_axi_wready  <= s_axi_wvalid && !s_axi_wready && !wHeld;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld     <= 1'b1;
        awAddrHeld <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld     <= 1'b1;
        wDataHeld <= s_axi_wdata;
        wStrbHeld <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? oag_pkg::RESP_OKAY : oag_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode; status is read only and a write to it is silently dropped
  logic [7:0]  rOfs;
  logic [31:0] statusWord;
  logic [31:0] readMux;
  logic        readHit;
  assign rOfs       = 8'(s_axi_araddr);
  assign statusWord = {4'h0, stackAddr, 1'b0, operandMode, operandAddr};
  assign readHit    = (rOfs == oag_pkg::OFS_CMD) || (rOfs == oag_pkg::OFS_STATUS)
                   || (rOfs == oag_pkg::OFS_IPTR) || (rOfs == oag_pkg::OFS_DPTR)
                   || (rOfs == oag_pkg::OFS_SPTR) || (rOfs == oag_pkg::OFS_MUL)
                   || (rOfs == oag_pkg::OFS_WORK);
  assign readMux    = (rOfs == oag_pkg::OFS_STATUS) ? statusWord
                    : (rOfs == oag_pkg::OFS_IPTR)   ? {16'h0000, indirectPtr}
                    : (rOfs == oag_pkg::OFS_DPTR)   ? {16'h0000, dataPtr}
                    : (rOfs == oag_pkg::OFS_SPTR)   ? {16'h0000, stackPtr}
                    : (rOfs == oag_pkg::OFS_MUL)    ? {16'h0000, multiply_high_reg, workReg}
                    : (rOfs == oag_pkg::OFS_WORK)   ? {24'h000000, workReg}
                    : 32'h0000_0000;

  // Read channel: one read in flight, data registered at the address handshake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= oag_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= readMux;
        s_axi_rresp  <= readHit ? oag_pkg::RESP_OKAY : oag_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: operand_address_generator_tb.sv
// Self-checking bench for the operand address generator
module operand_address_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [11:0] operandAddr, stackAddr;
  logic [2:0]  operandMode;
  logic        operandStrobe, stackStrobe, stackPush;
  int          failures, totalChecks;

  oag_top u_oag_top (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .operandAddr, .operandMode,
    .operandStrobe, .stackAddr, .stackStrobe, .stackPush);
  oag_mem_model u_oag_mem_model (.clk, .rst, .operandAddr, .operandMode, .operandStrobe, .stackAddr,
    .stackStrobe, .stackPush);

  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic stop_test;
    $display("Checks %0d failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together; each released on its own ready
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 40) begin
      failures++;
      stop_test();
    end
  endtask

  // Ready is raised late on purpose so the data must hold while it waits
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 40) begin
      failures++;
      stop_test();
    end
  endtask

  task automatic expectReg(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] expResp);
    logic [31:0] d;
    logic [1:0]  r;
    axiRead(a, d, r);
    check(d, exp);
    check(32'(r), 32'(expResp));
  endtask

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] expResp);
    logic [1:0] r;
    axiWrite(a, d, r);
    check(32'(r), 32'(expResp));
  endtask

  // One command word, then an edge so the model has recorded its strobes
  task automatic doCmd(input logic [3:0] op, input logic [8:0] field, input logic [7:0] imm, input logic [1:0] sel);
    regWrite(oag_pkg::OFS_CMD, {6'h00, sel, imm, 3'h0, op, field}, oag_pkg::RESP_OKAY);
    @(posedge clk);
  endtask

  task automatic addrCase(input logic [8:0] field, input logic [11:0] expA, input logic [2:0] m);
    int cnt;
    cnt = u_oag_mem_model.opCount;
    doCmd(oag_pkg::OP_ADDR, field, 8'h00, 2'h0);
    check(32'(u_oag_mem_model.opCount), 32'(cnt + 1));
    check(32'(u_oag_mem_model.lastOpAddr), 32'(expA));
    check(32'(u_oag_mem_model.lastMode), 32'(m));
  endtask

  task automatic test_modes;
    addrCase(9'h002, 12'h002, oag_pkg::MODE_SPECIAL);
    addrCase(9'h07F, 12'h07F, oag_pkg::MODE_SPECIAL);
    addrCase(9'h080, 12'h080, oag_pkg::MODE_GLOBAL);
    addrCase(9'h0FF, 12'h0FF, oag_pkg::MODE_GLOBAL);
    regWrite(oag_pkg::OFS_IPTR, 32'h0000F385, oag_pkg::RESP_OKAY);
    addrCase(9'h000, 12'h385, oag_pkg::MODE_INDIRECT);
    doCmd(oag_pkg::OP_LOADH, 9'h002, 8'hF3, 2'h0);
    doCmd(oag_pkg::OP_LOADL, 9'h002, 8'h85, 2'h0);
    expectReg(oag_pkg::OFS_DPTR, 32'h0000F385, oag_pkg::RESP_OKAY);
    addrCase(9'h108, 12'h38D, oag_pkg::MODE_DP_OFFSET);
    regWrite(oag_pkg::OFS_SPTR, 32'h00000FFA, oag_pkg::RESP_OKAY);
    addrCase(9'h1FF, 12'h079, oag_pkg::MODE_SP_OFFSET);
  endtask

  // Carry and borrow into the high byte on the indirect pointer, borrow on the data pointer, carry on the stack pointer
  task automatic test_carry;
    regWrite(oag_pkg::OFS_IPTR, 32'h000000FF, oag_pkg::RESP_OKAY);
    doCmd(oag_pkg::OP_ADD, 9'h002, 8'h01, oag_pkg::SEL_IPTR);
    expectReg(oag_pkg::OFS_IPTR, 32'h00000100, oag_pkg::RESP_OKAY);
    doCmd(oag_pkg::OP_SUB, 9'h002, 8'h01, oag_pkg::SEL_IPTR);
    expectReg(oag_pkg::OFS_IPTR, 32'h000000FF, oag_pkg::RESP_OKAY);
    doCmd(oag_pkg::OP_SUB, 9'h002, 8'h86, oag_pkg::SEL_DPTR);
    expectReg(oag_pkg::OFS_DPTR, 32'h0000F2FF, oag_pkg::RESP_OKAY);
    doCmd(oag_pkg::OP_ADD, 9'h002, 8'h06, oag_pkg::SEL_SPTR);
    expectReg(oag_pkg::OFS_SPTR, 32'h00001000, oag_pkg::RESP_OKAY);
  endtask

  task automatic test_stack;
    regWrite(oag_pkg::OFS_SPTR, 32'h00000200, oag_pkg::RESP_OKAY);
    doCmd(oag_pkg::OP_PUSH, 9'h180, 8'h00, 2'h0);
    check(32'(u_oag_mem_model.lastPush), 32'h00000001);
    check(32'(u_oag_mem_model.lastStackAddr), 32'h00000200);
    expectReg(oag_pkg::OFS_SPTR, 32'h000001FF, oag_pkg::RESP_OKAY);
    doCmd(oag_pkg::OP_POP, 9'h180, 8'h00, 2'h0);
    check(32'(u_oag_mem_model.lastPush), 32'h00000000);
    check(32'(u_oag_mem_model.lastOpAddr), 32'h000001FF);
    check(32'(u_oag_mem_model.lastStackAddr), 32'h00000200);
    expectReg(oag_pkg::OFS_STATUS, 32'h020041FF, oag_pkg::RESP_OKAY);
  endtask

  task automatic test_mul;
    regWrite(oag_pkg::OFS_WORK, 32'h000000FE, oag_pkg::RESP_OKAY);
    doCmd(oag_pkg::OP_MULU, 9'h002, 8'h03, 2'h0);
    expectReg(oag_pkg::OFS_MUL, 32'h000002FA, oag_pkg::RESP_OKAY);
    expectReg(oag_pkg::OFS_WORK, 32'h000000FA, oag_pkg::RESP_OKAY);
    regWrite(oag_pkg::OFS_WORK, 32'h000000FE, oag_pkg::RESP_OKAY);
    doCmd(oag_pkg::OP_MULS, 9'h002, 8'h03, 2'h0);
    expectReg(oag_pkg::OFS_MUL, 32'h0000FFFA, oag_pkg::RESP_OKAY);
  endtask

  // Unmapped place refused; command word reads back empty
  task automatic test_bus;
    regWrite(8'h1C, 32'h12345678, oag_pkg::RESP_SLVERR);
    expectReg(8'h1C, 32'h00000000, oag_pkg::RESP_SLVERR);
    expectReg(oag_pkg::OFS_CMD, 32'h00000000, oag_pkg::RESP_OKAY);
    check(32'(u_oag_mem_model.misuse), 32'h00000000);
  endtask

  // Main sequence: reset for four cycles, then each scenario in turn
  initial begin
    failures = 0;
    totalChecks = 0;
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    test_modes();
    test_carry();
    test_stack();
    test_mul();
    test_bus();
    stop_test();
  end
endmodule
